//--- rtl/fcl_pkg.sv
// Shared constants and types for the fully-closed loop supervision block.
// Assumes a single 100 MHz clock domain and an AXI4-Lite register master.
package fcl_pkg;

    // ---------------------------------------------------------------
    // Register byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] OFF_ERROR_LEVEL = 8'h00;
    localparam logic [7:0] OFF_MULTIPLIER = 8'h04;
    localparam logic [7:0] OFF_MON_ONE = 8'h08;
    localparam logic [7:0] OFF_MON_TWO = 8'h0C;
    localparam logic [7:0] OFF_SPEED_SEL = 8'h10;
    localparam logic [7:0] OFF_EXT_USAGE = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    localparam logic [7:0] OFF_MASK = 8'h1C;
    localparam logic [7:0] OFF_DEVIATION = 8'h20;
    localparam logic [7:0] OFF_ACTIVE = 8'h24;

    // ---------------------------------------------------------------
    // Reset values and limits
    // ---------------------------------------------------------------
    localparam logic [31:0] ERROR_LEVEL_RESET = 32'h0000_03E8;
    localparam logic [31:0] ERROR_LEVEL_MAX = 32'h4000_0000;
    localparam logic [7:0] MULTIPLIER_RESET = 8'h14;
    localparam logic [7:0] MULTIPLIER_MAX = 8'h64;
    localparam logic [15:0] SELECT_RESET = 16'h0000;
    localparam logic [1:0] STATUS_RESET = 2'h0;

    // ---------------------------------------------------------------
    // Field positions and codes
    // ---------------------------------------------------------------
    localparam int DIGIT_HI = 15;
    localparam int DIGIT_LO = 12;
    localparam logic [7:0] MON_CODE_DEVIATION = 8'h07;
    localparam logic [3:0] USAGE_NONE = 4'h0;
    localparam logic [3:0] USAGE_FORWARD = 4'h1;
    localparam logic [3:0] USAGE_REVERSE = 4'h3;
    localparam logic [3:0] SPEED_SRC_EXTERNAL = 4'h1;
    localparam int ST_OVERFLOW = 0;
    localparam int ST_CARRY_DONE = 1;
    localparam int STATUS_BITS = 2;

    // ---------------------------------------------------------------
    // Arithmetic and bus answers
    // ---------------------------------------------------------------
    localparam int PROD_W = 40;
    localparam logic [PROD_W-1:0] PERCENT_DIVISOR = 40'h00_0000_0064;
    localparam logic [7:0] PERCENT_FULL = 8'h64;
    localparam logic [15:0] MON_POS_SAT = 16'h7FFF;
    localparam logic [15:0] MON_NEG_SAT = 16'h8000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic signed [31:0] motor_pos;
        logic signed [31:0] load_pos;
        logic signed [31:0] motor_speed;
        logic signed [31:0] ext_speed;
    } feedback_t;

    typedef enum logic [1:0] {
        CARRY_IDLE,
        CARRY_DIVIDE,
        CARRY_APPLY
    } carry_state_t;

endpackage : fcl_pkg

//--- rtl/percent_divider.sv
// Restoring divider that divides a product by the percent divisor.
// Assumes start is a pulse taken only while done is high (idle).
`timescale 1ns/1ps
module percent_divider
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic start,
    input wire logic [fcl_pkg::PROD_W-1:0] dividend,
    output logic [fcl_pkg::PROD_W-1:0] quotient,
    output logic done
);
    import fcl_pkg::*;

    logic [PROD_W-1:0] rem;
    logic [5:0] count;
    logic [PROD_W:0] trial;

    always_comb
    begin
        trial = {rem, quotient[PROD_W-1]} - {1'b0, PERCENT_DIVISOR};
    end

    // ---------------------------------------------------------------
    // One quotient bit per cycle
    // ---------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rem <= '0;
            quotient <= '0;
            count <= '0;
            done <= 1'b1;
        end
        else if (ce)
        begin
            if (start && done)
            begin
                rem <= '0;
                quotient <= dividend;
                count <= 6'(PROD_W);
                done <= 1'b0;
            end
            else if (!done)
            begin
                if (!trial[PROD_W])
                begin
                    rem <= trial[PROD_W-1:0];
                    quotient <= {quotient[PROD_W-2:0], 1'b1};
                end
                else
                begin
                    rem <= {rem[PROD_W-2:0], quotient[PROD_W-1]};
                    quotient <= {quotient[PROD_W-2:0], 1'b0};
                end
                count <= count - 6'h01;
                done <= (count == 6'h01);
            end
        end
    end

endmodule : percent_divider

//--- rtl/fcl_supervisor.sv
// Fully-closed loop supervision: motor/load deviation, alarm, monitors.
// Assumes synchronous feedback inputs and an AXI4-Lite master on aclk.
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module fcl_supervisor
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire fcl_pkg::feedback_t feedback,
    input wire logic position_cycle,
    input wire logic rotation_start,
    input wire logic restart,
    output logic signed [31:0] speed_feedback,
    output logic signed [15:0] monitor_one,
    output logic signed [15:0] monitor_two,
    output logic motor_load_error_overflow_alarm,
    output logic irq
);
    import fcl_pkg::*;

    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    logic [31:0] motor_load_error_level;
    logic [7:0] rotation_deviation_multiplier;
    logic [15:0] analog_monitor_one_select;
    logic [15:0] analog_monitor_two_select;
    logic [15:0] speed_feedback_source_select;
    logic [15:0] external_encoder_usage;
    logic [3:0] active_usage;
    logic [3:0] active_speed_src;
    logic [STATUS_BITS-1:0] status;
    logic [STATUS_BITS-1:0] mask;
    logic [STATUS_BITS-1:0] status_set;
    logic [STATUS_BITS-1:0] status_clr;
    logic aw_held;
    logic w_held;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_fire;
    logic wr_hit;
    logic rd_hit;
    logic [31:0] rd_value;
    logic ext_used;
    logic signed [31:0] load_eff;
    logic signed [31:0] raw_dev;
    logic signed [31:0] deviation;
    logic signed [31:0] deviation_q;
    logic signed [31:0] carry_offset;
    logic signed [31:0] raw_at_start;
    logic signed [31:0] carried;
    logic [31:0] dev_mag;
    logic carry_neg;
    logic [PROD_W-1:0] product;
    logic [PROD_W-1:0] quotient;
    logic div_start;
    logic div_done;
    logic [31:0] next_level;
    logic [31:0] next_mult;
    logic signed [15:0] mon_value;
    carry_state_t carry_state;

    function automatic logic [31:0] merge
    (
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    // ---------------------------------------------------------------
    // Write channel
    // ---------------------------------------------------------------
    assign s_axi_awready = ce && !aw_held && !s_axi_bvalid;
    assign s_axi_wready = ce && !w_held && !s_axi_bvalid;
    assign wr_fire = ce && aw_held && w_held && !s_axi_bvalid;

    always_comb
    begin
        unique case (wr_addr)
            OFF_ERROR_LEVEL, OFF_MULTIPLIER, OFF_MON_ONE, OFF_MON_TWO,
            OFF_SPEED_SEL, OFF_EXT_USAGE, OFF_STATUS, OFF_MASK:
                wr_hit = 1'b1;
            default:
                wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wr_addr <= '0;
            wr_data <= '0;
            wr_strb <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else if (ce)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                wr_addr <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // Setting registers
    // ---------------------------------------------------------------
    always_comb
    begin
        next_level = merge(motor_load_error_level, wr_data, wr_strb);
        next_mult = merge({24'h0, rotation_deviation_multiplier}, wr_data,
            wr_strb);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            motor_load_error_level <= ERROR_LEVEL_RESET;
            rotation_deviation_multiplier <= MULTIPLIER_RESET;
            analog_monitor_one_select <= SELECT_RESET;
            analog_monitor_two_select <= SELECT_RESET;
            speed_feedback_source_select <= SELECT_RESET;
            external_encoder_usage <= SELECT_RESET;
            mask <= '0;
        end
        else if (ce && wr_fire)
        begin
            unique case (wr_addr)
                OFF_ERROR_LEVEL:
                    motor_load_error_level <= (next_level > ERROR_LEVEL_MAX)
                        ? ERROR_LEVEL_MAX : next_level;
                OFF_MULTIPLIER:
                    rotation_deviation_multiplier <=
                        (next_mult > {24'h0, MULTIPLIER_MAX})
                        ? MULTIPLIER_MAX : next_mult[7:0];
                OFF_MON_ONE:
                    analog_monitor_one_select <= 16'(merge(
                        {16'h0, analog_monitor_one_select}, wr_data, wr_strb));
                OFF_MON_TWO:
                    analog_monitor_two_select <= 16'(merge(
                        {16'h0, analog_monitor_two_select}, wr_data, wr_strb));
                OFF_SPEED_SEL:
                    speed_feedback_source_select <= 16'(merge(
                        {16'h0, speed_feedback_source_select}, wr_data,
                        wr_strb));
                OFF_EXT_USAGE:
                    external_encoder_usage <= 16'(merge(
                        {16'h0, external_encoder_usage}, wr_data, wr_strb));
                OFF_MASK:
                    mask <= STATUS_BITS'(merge({30'h0, mask}, wr_data,
                        wr_strb));
                default:
                    ;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Settings taken at restart
    // ---------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            active_usage <= USAGE_NONE;
            active_speed_src <= '0;
        end
        else if (ce && restart)
        begin
            active_usage <= external_encoder_usage[DIGIT_HI:DIGIT_LO];
            active_speed_src <=
                speed_feedback_source_select[DIGIT_HI:DIGIT_LO];
        end
    end

    assign ext_used = (active_usage == USAGE_FORWARD)
        || (active_usage == USAGE_REVERSE);
    assign load_eff = (active_usage == USAGE_REVERSE)
        ? -feedback.load_pos : feedback.load_pos;

    assign speed_feedback = ext_used && active_speed_src == SPEED_SRC_EXTERNAL
        ? feedback.ext_speed : feedback.motor_speed;

    // ---------------------------------------------------------------
    // Deviation and per-rotation carry
    // ---------------------------------------------------------------
    assign raw_dev = feedback.motor_pos - load_eff;
    assign deviation = raw_dev - carry_offset;
    assign dev_mag = deviation[31] ? 32'(-deviation) : 32'(deviation);
    assign product = PROD_W'(dev_mag) * PROD_W'(PERCENT_FULL
        - rotation_deviation_multiplier);
    assign div_start = (carry_state == CARRY_IDLE) && rotation_start
        && (rotation_deviation_multiplier != '0);
    assign carried = carry_neg ? -32'(quotient) : 32'(quotient);

    percent_divider u_divider
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .start(div_start),
        .dividend(product),
        .quotient(quotient),
        .done(div_done)
    );

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            carry_state <= CARRY_IDLE;
            carry_offset <= '0;
            raw_at_start <= '0;
            carry_neg <= 1'b0;
        end
        else if (ce)
        begin
            unique case (carry_state)
                CARRY_IDLE:
                    if (rotation_start)
                    begin
                        if (rotation_deviation_multiplier == '0)
                        begin
                            carry_offset <= '0;
                        end
                        else
                        begin
                            raw_at_start <= raw_dev;
                            carry_neg <= deviation[31];
                            carry_state <= CARRY_DIVIDE;
                        end
                    end
                CARRY_DIVIDE:
                    if (div_done)
                    begin
                        carry_state <= CARRY_APPLY;
                    end
                CARRY_APPLY:
                begin
                    carry_offset <= raw_at_start - carried;
                    carry_state <= CARRY_IDLE;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Alarm check and status
    // ---------------------------------------------------------------
    always_comb
    begin
        status_set = '0;
        status_set[ST_OVERFLOW] = position_cycle
            && (motor_load_error_level != '0)
            && (dev_mag > motor_load_error_level);
        status_set[ST_CARRY_DONE] = (carry_state == CARRY_APPLY)
            || (carry_state == CARRY_IDLE && rotation_start
            && rotation_deviation_multiplier == '0);
        status_clr = '0;
        if (wr_fire && wr_addr == OFF_STATUS && wr_strb[0])
        begin
            status_clr = wr_data[STATUS_BITS-1:0];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            status <= STATUS_RESET;
            deviation_q <= '0;
        end
        else if (ce)
        begin
            status <= (status & ~status_clr) | status_set;
            if (position_cycle)
            begin
                deviation_q <= deviation;
            end
        end
    end

    assign motor_load_error_overflow_alarm = status[ST_OVERFLOW];
    assign irq = |(status & mask);

    // ---------------------------------------------------------------
    // Analog monitors
    // ---------------------------------------------------------------
    always_comb
    begin
        if (deviation_q > 32'sd32767)
        begin
            mon_value = MON_POS_SAT;
        end
        else if (deviation_q < -32'sd32768)
        begin
            mon_value = MON_NEG_SAT;
        end
        else
        begin
            mon_value = deviation_q[15:0];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            monitor_one <= '0;
            monitor_two <= '0;
        end
        else if (ce)
        begin
            monitor_one <= (analog_monitor_one_select[7:0]
                == MON_CODE_DEVIATION) ? mon_value : '0;
            monitor_two <= (analog_monitor_two_select[7:0]
                == MON_CODE_DEVIATION) ? mon_value : '0;
        end
    end

    // ---------------------------------------------------------------
    // Read channel
    // ---------------------------------------------------------------
    assign s_axi_arready = ce && !s_axi_rvalid;

    always_comb
    begin
        rd_hit = 1'b1;
        unique case ({s_axi_araddr[7:2], 2'b00})
            OFF_ERROR_LEVEL: rd_value = motor_load_error_level;
            OFF_MULTIPLIER: rd_value = {24'h0, rotation_deviation_multiplier};
            OFF_MON_ONE: rd_value = {16'h0, analog_monitor_one_select};
            OFF_MON_TWO: rd_value = {16'h0, analog_monitor_two_select};
            OFF_SPEED_SEL: rd_value = {16'h0, speed_feedback_source_select};
            OFF_EXT_USAGE: rd_value = {16'h0, external_encoder_usage};
            OFF_STATUS: rd_value = {30'h0, status};
            OFF_MASK: rd_value = {30'h0, mask};
            OFF_DEVIATION: rd_value = deviation_q;
            OFF_ACTIVE: rd_value = {24'h0, active_speed_src, active_usage};
            default:
            begin
                rd_value = '0;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (ce)
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_value;
                s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule : fcl_supervisor

//--- dv/fcl_checker_asserts.sv
// Checker: bus handshake and alarm timing at the block ports.
// Bound to fcl_supervisor from the testbench top file.
`timescale 1ns/1ps
module fcl_checker
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic position_cycle,
    input wire logic motor_load_error_overflow_alarm
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ----------------------------------------------------------
    // Bus handshake
    // ----------------------------------------------------------
    ready_gate_a: assert property (!ce |-> !s_axi_awready && !s_axi_wready
        && !s_axi_arready) else $error("ready high while frozen");
    wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready
        && !s_axi_wready) else $error("write taken during response");
    rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken during response");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read response late");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read response dropped");
    // ----------------------------------------------------------
    // Alarm
    // ----------------------------------------------------------
    alarm_cause_a: assert property (
        $rose(motor_load_error_overflow_alarm) |-> $past(position_cycle))
        else $error("alarm rose without position cycle");
    alarm_hold_a: assert property (
        $fell(motor_load_error_overflow_alarm) |-> ##[0:1] s_axi_bvalid)
        else $error("alarm cleared without write");
    cover property ($rose(motor_load_error_overflow_alarm));
    cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h2);
    cover property (s_axi_rvalid && s_axi_rready);
endmodule : fcl_checker

//--- dv/enc_model.sv
// Motor encoder and external load encoder model.
// Assumes the bench sets target positions; values move on aclk.
`timescale 1ns/1ps
module enc_model
#(
    parameter int MOTOR_SPEED = 111,
    parameter int EXT_SPEED = 222
)
(
    input wire logic aclk,
    input wire logic signed [31:0] motor_set,
    input wire logic signed [31:0] load_set,
    output fcl_pkg::feedback_t feedback
);
    import fcl_pkg::*;
    always_ff @(posedge aclk)
    begin
        feedback.motor_pos <= motor_set;
        feedback.load_pos <= load_set;
        feedback.motor_speed <= 32'(MOTOR_SPEED);
        feedback.ext_speed <= 32'(EXT_SPEED);
    end
endmodule : enc_model

//--- dv/testbench.sv
// Testbench for fcl_supervisor: bus tasks, one task per scenario.
// Assumes the encoder model drives feedback; clock 100 MHz.
`timescale 1ns/1ps
module testbench;
    import fcl_pkg::*;
    logic aclk = 0, aresetn = 0, ce = 1;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, rv;
    feedback_t feedback;
    logic position_cycle = 0, rotation_start = 0, restart = 0;
    logic signed [31:0] speed_feedback, motor_set = 0, load_set = 0;
    logic signed [15:0] monitor_one, monitor_two;
    logic motor_load_error_overflow_alarm;
    int err_total = 0, num_checks = 0;
    always #5 aclk = ~aclk;
    fcl_supervisor i_fcl_supervisor (.aclk, .aresetn, .ce, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .feedback,
        .position_cycle, .rotation_start, .restart, .speed_feedback,
        .monitor_one, .monitor_two, .motor_load_error_overflow_alarm, .irq);
    enc_model i_enc_model (.aclk, .motor_set, .load_set, .feedback);
    task automatic chk(input string n, logic [31:0] e, g);
        num_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] r = RESP_OKAY);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {32'(a), d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 0;
        end
        while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 0;
        chk("bresp", 32'(r), 32'(s_axi_bresp));
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [1:0] r = RESP_OKAY);
        @(posedge aclk);
        s_axi_araddr <= 32'(a);
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 0;
        end
        while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 0;
        rv = s_axi_rdata;
        chk("rresp", 32'(r), 32'(s_axi_rresp));
    endtask : rd
    task automatic tick(input logic [1:0] k);
        @(posedge aclk);
        {restart, rotation_start, position_cycle} <= {k == 2, k == 1, k == 0};
        @(posedge aclk);
        {restart, rotation_start, position_cycle} <= 3'h0;
        repeat (2) @(posedge aclk);
    endtask : tick
    task automatic t_regs();
        rd(OFF_ERROR_LEVEL);
        chk("level", ERROR_LEVEL_RESET, rv);
        rd(OFF_MULTIPLIER);
        chk("mult", 32'(MULTIPLIER_RESET), rv);
        rd(8'h40, RESP_SLVERR);
        wr(8'h40, 32'h1, RESP_SLVERR);
        ce <= 0;
        repeat (3) @(posedge aclk);
        ce <= 1;
        wr(OFF_ERROR_LEVEL, 32'hFFFF_FFFF);
        rd(OFF_ERROR_LEVEL);
        chk("level max", ERROR_LEVEL_MAX, rv);
        wr(OFF_MULTIPLIER, 32'h65);
        rd(OFF_MULTIPLIER);
        chk("mult max", 32'h64, rv);
    endtask : t_regs
    task automatic t_alarm();
        wr(OFF_MON_ONE, 32'h7);
        wr(OFF_ERROR_LEVEL, 32'hA);
        wr(OFF_MASK, 32'h1);
        {motor_set, load_set} <= {32'sd100, 32'sd90};
        tick(0);
        chk("alarm", 0, 32'(motor_load_error_overflow_alarm));
        chk("mon1", 32'hA, 32'(monitor_one));
        chk("mon2", 0, 32'(monitor_two));
        load_set <= 89;
        tick(0);
        chk("alarm", 1, 32'(motor_load_error_overflow_alarm));
        chk("irq", 1, 32'(irq));
        load_set <= 90;
        tick(0);
        chk("alarm", 1, 32'(motor_load_error_overflow_alarm));
        wr(OFF_MASK, 32'h0);
        chk("irq", 0, 32'(irq));
        wr(OFF_STATUS, 32'h1);
        chk("alarm", 0, 32'(motor_load_error_overflow_alarm));
        wr(OFF_ERROR_LEVEL, 32'h0);
        load_set <= -1000;
        tick(0);
        chk("alarm", 0, 32'(motor_load_error_overflow_alarm));
        wr(OFF_ERROR_LEVEL, 32'h3E8);
        tick(0);
        chk("alarm", 1, 32'(motor_load_error_overflow_alarm));
        wr(OFF_STATUS, 32'h1);
    endtask : t_alarm
    task automatic t_speed();
        wr(OFF_SPEED_SEL, 32'h1000);
        tick(2);
        chk("speed", 111, speed_feedback);
        wr(OFF_EXT_USAGE, 32'h1000);
        chk("speed", 111, speed_feedback);
        tick(2);
        chk("speed", 222, speed_feedback);
        rd(OFF_ACTIVE);
        chk("active", 32'h11, rv);
        wr(OFF_EXT_USAGE, 32'h3000);
        wr(OFF_MON_TWO, 32'h7);
        tick(2);
        load_set <= 50;
        tick(0);
        chk("mon1 rev", 32'd150, 32'(monitor_one));
        chk("mon2 rev", 32'd150, 32'(monitor_two));
        wr(OFF_EXT_USAGE, 32'h2000);
        tick(2);
        chk("speed rsv", 111, speed_feedback);
        load_set <= 0;
    endtask : t_speed
    task automatic t_rot(input logic [31:0] m, input logic [31:0] e);
        wr(OFF_MULTIPLIER, m);
        tick(0);
        tick(1);
        repeat (100)
        begin
            rd(OFF_STATUS);
            if (rv[ST_CARRY_DONE] === 1'b1) break;
        end
        chk("carry", 1, 32'(rv[ST_CARRY_DONE]));
        wr(OFF_STATUS, 32'h2);
        tick(0);
        chk("mon1 rot", e, 32'(monitor_one));
    endtask : t_rot
    task automatic print_verdict();
        if (err_total == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : print_verdict
    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1;
        t_regs();
        t_alarm();
        t_speed();
        t_rot(32'h14, 32'd80);
        t_rot(32'h0, 32'd100);
        print_verdict();
    end
    initial
    begin
        repeat (20000) @(posedge aclk);
        err_total++;
        print_verdict();
    end
endmodule : testbench
bind fcl_supervisor fcl_checker i_fcl_checker (.aclk, .aresetn, .ce,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .position_cycle, .motor_load_error_overflow_alarm);
